// ---- rtl/itwd_host.sv ----
// Core-side controller for the idle timer and watchdog device.
// Assumes an APB master on ref_clk; one link operation at a time.
`timescale 1ns/1ps
`include "itwd_consts.svh"

module itwd_host (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt.
   output logic irq_out,
   // Link to the device.
   itwd_if.core lnk
);

   // =========================================================================
   // Declarations.
   itwd_pkg::itwd_hst_t st_q;
   logic op_wr_q;
   logic op_addr_q;
   logic [7:0] op_data_q;
   logic [7:0] rd_q;
   logic [2:0] cfg_q;
   logic fwr_q;
   logic fval_q;
   logic [`ITWD_EV_W-1:0] stat_q;
   logic [`ITWD_EV_W-1:0] mask_q;
   logic irq_prev_q;
   logic irq_out_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic acc;
   logic wr_go;
   logic idle;
   logic mapped;
   logic [`ITWD_EV_W-1:0] ev;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // =========================================================================
   // APB decode; a transfer completes when the access phase sees pready.
   assign acc = psel && penable && pready_q;
   assign wr_go = acc && pwrite;
   assign idle = (st_q == itwd_pkg::HS_IDLE);
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `ITWD_APB_STATE);
   assign ev = {lnk.wdt_rst, lnk.irq && !irq_prev_q};

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= `ITWD_WORD_ZERO;
      end else begin
         pready_q <= psel && !penable && !pready_q;
         pslverr_q <= psel && !penable && !pready_q && !mapped;
         prdata_q <= `ITWD_WORD_ZERO;
         if (psel && !penable && !pwrite) begin
            if (hit(paddr, `ITWD_APB_CTRL_RD)) begin
               prdata_q <= {24'h00_0000, rd_q};
            end else if (hit(paddr, `ITWD_APB_CONFIG)) begin
               prdata_q <= {29'h0000_0000, cfg_q};
            end else if (hit(paddr, `ITWD_APB_ISTAT)) begin
               prdata_q <= {30'h0000_0000, stat_q};
            end else if (hit(paddr, `ITWD_APB_IMASK)) begin
               prdata_q <= {30'h0000_0000, mask_q};
            end else if (hit(paddr, `ITWD_APB_STATE)) begin
               prdata_q <= {30'h0000_0000, lnk.irq, !idle};
            end
         end
      end
   end

   // =========================================================================
   // Configuration levels and fuse write pulse.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q <= 3'b000;
         mask_q <= `ITWD_EV_ZERO;
         fwr_q <= 1'b0;
         fval_q <= 1'b0;
      end else begin
         fwr_q <= wr_go && hit(paddr, `ITWD_APB_FUSE);
         if (wr_go && hit(paddr, `ITWD_APB_FUSE)) begin
            fval_q <= pwdata[0];
         end
         if (wr_go && hit(paddr, `ITWD_APB_CONFIG)) begin
            cfg_q <= pwdata[2:0];
         end
         if (wr_go && hit(paddr, `ITWD_APB_IMASK)) begin
            mask_q <= pwdata[`ITWD_EV_W-1:0];
         end
      end
   end

   // =========================================================================
   // Sticky events; a new event wins over a write-one-to-clear.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_q <= `ITWD_EV_ZERO;
         irq_prev_q <= 1'b0;
         irq_out_q <= 1'b0;
      end else begin
         irq_prev_q <= lnk.irq;
         if (wr_go && hit(paddr, `ITWD_APB_ISTAT)) begin
            stat_q <= (stat_q & ~pwdata[`ITWD_EV_W-1:0]) | ev;
         end else begin
            stat_q <= stat_q | ev;
         end
         irq_out_q <= |(stat_q & mask_q);
      end
   end

   // =========================================================================
   // Link sequencer; commands while busy are dropped.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= itwd_pkg::HS_IDLE;
         op_wr_q <= 1'b0;
         op_addr_q <= `ITWD_ADDR_CTRL;
         op_data_q <= `ITWD_BYTE_ZERO;
         rd_q <= `ITWD_BYTE_ZERO;
      end else begin
         case (st_q)
            itwd_pkg::HS_IDLE: begin
               if (wr_go && hit(paddr, `ITWD_APB_CTRL_WR)) begin
                  op_wr_q <= 1'b1;
                  op_addr_q <= `ITWD_ADDR_CTRL;
                  op_data_q <= pwdata[7:0];
                  st_q <= itwd_pkg::HS_REQ;
               end else if (wr_go && hit(paddr, `ITWD_APB_SVC_WR)) begin
                  op_wr_q <= 1'b1;
                  op_addr_q <= `ITWD_ADDR_SVC;
                  op_data_q <= pwdata[7:0];
                  st_q <= itwd_pkg::HS_REQ;
               end else if (wr_go && hit(paddr, `ITWD_APB_CTRL_RD)) begin
                  op_wr_q <= 1'b0;
                  op_addr_q <= `ITWD_ADDR_CTRL;
                  st_q <= itwd_pkg::HS_REQ;
               end
            end
            itwd_pkg::HS_REQ: begin
               st_q <= itwd_pkg::HS_WAIT;
            end
            itwd_pkg::HS_WAIT: begin
               if (lnk.reg_ack) begin
                  if (!op_wr_q) begin
                     rd_q <= lnk.reg_rdata;
                  end
                  st_q <= itwd_pkg::HS_IDLE;
               end
            end
            default: begin
               st_q <= itwd_pkg::HS_IDLE;
            end
         endcase
      end
   end

   // =========================================================================
   // Outputs.
   assign lnk.reg_sel = (st_q == itwd_pkg::HS_REQ);
   assign lnk.reg_wr = op_wr_q;
   assign lnk.reg_addr = op_addr_q;
   assign lnk.reg_wdata = op_data_q;
   assign lnk.gie = cfg_q[`ITWD_CFG_GIE];
   assign lnk.prog_mode = cfg_q[`ITWD_CFG_PROG];
   assign lnk.write_protect = cfg_q[`ITWD_CFG_WP];
   assign lnk.fuse_wr = fwr_q;
   assign lnk.fuse_val = fval_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq_out = irq_out_q;

endmodule : itwd_host

// ---- rtl/itwd_consts.svh ----
// Constants shared by both ends of the idle timer and watchdog link.
// Assumes inclusion by bare name from files under rtl/.
`ifndef ITWD_CONSTS_SVH
`define ITWD_CONSTS_SVH

// =============================================================================
// Idle counter.
`define ITWD_CNT_W 12
`define ITWD_CNT_ZERO 12'h000
`define ITWD_CNT_ALL1 12'hfff
`define ITWD_CNT_ONE 12'h001

// =============================================================================
// Device registers on the link.
`define ITWD_ADDR_CTRL 1'b0
`define ITWD_ADDR_SVC 1'b1
`define ITWD_CTRL_FLAG 7
`define ITWD_CTRL_WAKE 6
`define ITWD_CTRL_IEN 5
`define ITWD_BYTE_ZERO 8'h00
`define ITWD_WD_KEY 8'h1b

// =============================================================================
// Watchdog window, in instruction cycles and in prescaler periods.
`define ITWD_WD_MIN_CYC 4096
`define ITWD_WD_MAX_CYC 61440
`define ITWD_PRESC_CYC 4096
`define ITWD_PER_W 4
`define ITWD_PER_ZERO 4'h0
`define ITWD_PER_ONE 4'h1

// =============================================================================
// Controller registers on APB (byte addresses).
`define ITWD_APB_CTRL_WR 8'h00
`define ITWD_APB_SVC_WR 8'h04
`define ITWD_APB_CTRL_RD 8'h08
`define ITWD_APB_CONFIG 8'h0c
`define ITWD_APB_FUSE 8'h10
`define ITWD_APB_ISTAT 8'h14
`define ITWD_APB_IMASK 8'h18
`define ITWD_APB_STATE 8'h1c
`define ITWD_CFG_GIE 0
`define ITWD_CFG_PROG 1
`define ITWD_CFG_WP 2
`define ITWD_EV_IRQ 0
`define ITWD_EV_WDT 1
`define ITWD_EV_W 2
`define ITWD_EV_ZERO 2'b00
`define ITWD_WORD_ZERO 32'h0000_0000

`endif

// ---- rtl/itwd_pkg.sv ----
// Types used by the core-side controller of the idle timer and watchdog link.
// Assumes nothing of its surroundings.
package itwd_pkg;

   // =========================================================================
   // Controller sequencer states.
   typedef enum logic [1:0] {
      HS_IDLE,
      HS_REQ,
      HS_WAIT
   } itwd_hst_t;

endpackage : itwd_pkg

// ---- rtl/itwd_if.sv ----
// Link between the idle timer and watchdog device and the core side.
// Assumes both ends run on the same ref_clk.
`timescale 1ns/1ps

interface itwd_if;

   // Register access from the core side.
   logic reg_sel;
   logic reg_wr;
   logic reg_addr;
   logic [7:0] reg_wdata;
   logic reg_ack;
   logic [7:0] reg_rdata;
   // Core levels.
   logic gie;
   logic prog_mode;
   logic write_protect;
   logic fuse_wr;
   logic fuse_val;
   // Device outputs.
   logic irq;
   logic wdt_rst;

   modport dev (
      input reg_sel, reg_wr, reg_addr, reg_wdata, gie, prog_mode,
      input write_protect, fuse_wr, fuse_val,
      output reg_ack, reg_rdata, irq, wdt_rst
   );

   modport core (
      output reg_sel, reg_wr, reg_addr, reg_wdata, gie, prog_mode,
      output write_protect, fuse_wr, fuse_val,
      input reg_ack, reg_rdata, irq, wdt_rst
   );

endinterface : itwd_if

// ---- rtl/itwd_dev.sv ----
// Idle timer with pending flag and windowed watchdog, device end.
// Assumes the core side drives the link synchronously to ref_clk.
`timescale 1ns/1ps
`include "itwd_consts.svh"

module itwd_dev #(
   parameter logic FUSE_INIT = 1'b0
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Link to the core side.
   itwd_if.dev lnk,
   // Timebase and reset request to the rest of the chip.
   output logic idle_base_tick,
   output logic sys_reset_req
);

   // =========================================================================
   // Derived constants.
   localparam logic [`ITWD_PER_W-1:0] MIN_PER =
      `ITWD_PER_W'(`ITWD_WD_MIN_CYC / `ITWD_PRESC_CYC);
   localparam logic [`ITWD_PER_W-1:0] MAX_PER =
      `ITWD_PER_W'(`ITWD_WD_MAX_CYC / `ITWD_PRESC_CYC);

   // =========================================================================
   // Declarations.
   logic [`ITWD_CNT_W-1:0] cnt_q;
   logic half_q;
   logic flag_q;
   logic ien_q;
   logic wake_q;
   logic fuse_q;
   logic [`ITWD_PER_W-1:0] per_q;
   logic wdt_q;
   logic ack_q;
   logic [7:0] rdata_q;
   logic irq_q;
   logic tick_q;
   logic ovf;
   logic flag_set;
   logic ctrl_wr;
   logic svc_wr;
   logic svc_ok;
   logic trip;

   // =========================================================================
   // Decode.
   assign ovf = (cnt_q == `ITWD_CNT_ALL1);
   // The divider passes every second overflow, starting with the first.
   assign flag_set = ovf && !half_q;
   assign ctrl_wr = lnk.reg_sel && lnk.reg_wr && (lnk.reg_addr == `ITWD_ADDR_CTRL);
   assign svc_wr = lnk.reg_sel && lnk.reg_wr && (lnk.reg_addr == `ITWD_ADDR_SVC);
   // Any other value written to the service register is ignored.
   assign svc_ok = svc_wr && (lnk.reg_wdata == `ITWD_WD_KEY);

   // =========================================================================
   // Idle counter.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= `ITWD_CNT_ZERO;
      end else if (wdt_q) begin
         cnt_q <= `ITWD_CNT_ZERO;
      end else begin
         // Free running; wraps from all ones to zero by itself.
         cnt_q <= cnt_q + `ITWD_CNT_ONE;
      end
   end

   // =========================================================================
   // Divide-by-two stage on overflows.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         half_q <= 1'b0;
      end else if (wdt_q) begin
         half_q <= 1'b0;
      end else if (ovf) begin
         half_q <= !half_q;
      end
   end

   // =========================================================================
   // Pending flag; a hardware set wins over a clearing write.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
      end else if (wdt_q) begin
         flag_q <= 1'b0;
      end else if (flag_set) begin
         flag_q <= 1'b1;
      end else if (ctrl_wr) begin
         flag_q <= lnk.reg_wdata[`ITWD_CTRL_FLAG];
      end
   end

   // =========================================================================
   // Control enables.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ien_q <= 1'b0;
         wake_q <= 1'b0;
      end else if (wdt_q) begin
         ien_q <= 1'b0;
         wake_q <= 1'b0;
      end else if (ctrl_wr) begin
         ien_q <= lnk.reg_wdata[`ITWD_CTRL_IEN];
         wake_q <= lnk.reg_wdata[`ITWD_CTRL_WAKE];
      end
   end

   // =========================================================================
   // Interrupt request, gated by the local and the global enable.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else if (wdt_q) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= flag_q && ien_q && lnk.gie;
      end
   end

   // =========================================================================
   // Register reads; every access is answered one cycle later.
   // The counter itself never reaches the read path.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         rdata_q <= `ITWD_BYTE_ZERO;
      end else begin
         ack_q <= lnk.reg_sel;
         if (lnk.reg_sel && !lnk.reg_wr) begin
            if (lnk.reg_addr == `ITWD_ADDR_CTRL) begin
               rdata_q <= {flag_q, wake_q, ien_q, 5'b0_0000};
            end else begin
               rdata_q <= `ITWD_BYTE_ZERO;
            end
         end
      end
   end

   // =========================================================================
   // Enable fuse.  It is non-volatile: only power-up reset loads it and a
   // watchdog reset leaves it alone, so the watchdog comes up enabled again.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fuse_q <= FUSE_INIT;
      end else if (lnk.prog_mode && lnk.fuse_wr) begin
         if (lnk.fuse_val) begin
            fuse_q <= 1'b1;
         end else if (!lnk.write_protect) begin
            fuse_q <= 1'b0;
         end
      end
   end

   // =========================================================================
   // Watchdog window, counted in prescaler periods since the last service.
   // Nothing here looks at an idle or halt state: the count only stops once it reaches MAX_PER.
   always_comb begin
      trip = 1'b0;
      if (fuse_q && !wdt_q) begin
         if (svc_ok && (per_q < MIN_PER)) begin
            trip = 1'b1;
         end else if (!svc_ok && ovf && (per_q >= MAX_PER - `ITWD_PER_ONE)) begin
            trip = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         per_q <= `ITWD_PER_ZERO;
      end else if (wdt_q || svc_ok) begin
         per_q <= `ITWD_PER_ZERO;
      end else if (ovf && (per_q != MAX_PER)) begin
         per_q <= per_q + `ITWD_PER_ONE;
      end
   end

   // =========================================================================
   // Watchdog reset pulse; it clears all state but the fuse and the read registers on the next edge.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wdt_q <= 1'b0;
      end else begin
         wdt_q <= trip;
      end
   end

   // =========================================================================
   // Timebase pulse for idle exit and halt start-up delay.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= ovf && !wdt_q;
      end
   end

   // =========================================================================
   // Outputs.
   assign lnk.reg_ack = ack_q;
   assign lnk.reg_rdata = rdata_q;
   assign lnk.irq = irq_q;
   assign lnk.wdt_rst = wdt_q;
   assign idle_base_tick = tick_q;
   assign sys_reset_req = wdt_q;

endmodule : itwd_dev

// ---- tb/itwd_props.sv ----
// Assertions on the link between the idle timer device and its controller.
// Assumes every input is a signal of itwd_if sampled on ref_clk.
`timescale 1ns/1ps

module itwd_props (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Register access.
   input wire logic reg_sel,
   input wire logic reg_wr,
   input wire logic reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic [7:0] reg_rdata,
   // Core levels.
   input wire logic gie,
   input wire logic prog_mode,
   input wire logic write_protect,
   input wire logic fuse_wr,
   input wire logic fuse_val,
   // Device outputs.
   input wire logic irq,
   input wire logic wdt_rst
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // ========================================
   // Cycles since the last key or trip, and whether a trip came with no key since.
   logic key_w;
   logic fon_q;
   logic [16:0] cnt_q;
   logic arm_q;
   assign key_w = reg_sel && reg_wr && reg_addr && reg_wdata == 8'h1b;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 17'h00000;
      end else if (key_w || wdt_rst || !fon_q) begin
         cnt_q <= 17'h00000;
      end else if (cnt_q != 17'h1ffff) begin
         cnt_q <= cnt_q + 17'h00001;
      end
   end

   // Fuse state as programmed by the core side; the window only binds while it is set.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fon_q <= 1'b0;
      end else if (fuse_wr && prog_mode && (fuse_val || !write_protect)) begin
         fon_q <= fuse_val;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         arm_q <= 1'b0;
      end else if (wdt_rst) begin
         arm_q <= 1'b1;
      end else if (key_w || (fuse_wr && prog_mode && !fuse_val && !write_protect)) begin
         arm_q <= 1'b0;
      end
   end

   // ========================================
   // Properties.
   a_ack_follows_sel: assert property (reg_sel |=> reg_ack)
      else $error("link access got no acknowledge");
   a_ack_has_cause: assert property (reg_ack |-> $past(reg_sel))
      else $error("acknowledge without access");
   a_sel_spacing: assert property (reg_sel |=> !reg_sel [*2])
      else $error("link accesses too close");
   a_ctrl_hidden: assert property (reg_sel && !reg_wr && !reg_addr |=> reg_rdata[4:0] == 5'h00)
      else $error("control read shows hidden bits");
   a_irq_needs_gie: assert property (irq |-> $past(gie))
      else $error("interrupt without global enable");
   a_ien_off_irq: assert property (reg_sel && reg_wr && !reg_addr && !reg_wdata[5] |-> ##2 !irq)
      else $error("interrupt with enable cleared");
   a_wdt_pulse: assert property (wdt_rst |=> !wdt_rst)
      else $error("watchdog reset longer than one cycle");
   a_early_trip: assert property (key_w && arm_q && cnt_q < 17'd4000 |-> ##[1:3] wdt_rst)
      else $error("early service did not reset");
   a_late_limit: assert property (cnt_q <= 17'd61450)
      else $error("watchdog missed its late limit");
   a_trip_timing: assert property (wdt_rst && !$past(key_w) && cnt_q > 17'd8 |-> cnt_q >= 17'd57340)
      else $error("watchdog reset too soon");

   c_key: cover property (key_w);
   c_irq: cover property ($rose(irq));
   c_trip: cover property (wdt_rst);
endmodule : itwd_props

// ---- tb/itwd_tb_top.sv ----
// Self-checking bench for the idle timer and watchdog link and its APB controller.
// Assumes both ends and the controller share one 100 MHz ref_clk.
`timescale 1ns/1ps

module itwd_tb_top;
   logic ref_clk;
   logic rst_b;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq_out;
   logic tick;
   logic sys_req;
   logic [31:0] q;
   int mismatches;
   int samples_checked;
   int cyc = 0;
   int trips = 0;
   int t0;

   itwd_if lnk ();
   itwd_dev itwd_dev_i (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk.dev),
      .idle_base_tick(tick), .sys_reset_req(sys_req));
   itwd_host itwd_host_i (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_out(irq_out), .lnk(lnk.core));
   itwd_props itwd_props_i (.ref_clk(ref_clk), .rst_b(rst_b), .reg_sel(lnk.reg_sel),
      .reg_wr(lnk.reg_wr), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
      .reg_ack(lnk.reg_ack), .reg_rdata(lnk.reg_rdata), .gie(lnk.gie),
      .prog_mode(lnk.prog_mode), .write_protect(lnk.write_protect), .fuse_wr(lnk.fuse_wr),
      .fuse_val(lnk.fuse_val), .irq(lnk.irq), .wdt_rst(lnk.wdt_rst));

   always #5 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (sys_req === 1'b1) begin
         trips <= trips + 1;
      end
   end

   // ========================================
   // Report, compare and bus tasks.
   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task give_up;
      chk(32'h0, 32'h1);
      complete_run();
   endtask : give_up

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) give_up();
      q = (w || pslverr) ? {31'h0, pslverr} : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task rd(input logic [7:0] a);
      xfer(a, 1'b0, 32'h0);
   endtask : rd

   task automatic busy_wait;
      int n;
      n = 0;
      do begin
         rd(8'h1c);
         n++;
      end while (q[0] !== 1'b0 && n < 10);
      if (n >= 10) give_up();
   endtask : busy_wait

   task ctl_chk(input logic [31:0] exp);
      wr(8'h08, 32'h0);
      busy_wait();
      rd(8'h08);
      chk(q, exp);
   endtask : ctl_chk

   task key(input logic [7:0] v);
      wr(8'h04, {24'h0, v});
      busy_wait();
   endtask : key

   task automatic wt(input logic trip, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while ((trip ? sys_req : tick) !== 1'b1 && n < lim);
      if (n >= lim) give_up();
   endtask : wt

   // ========================================
   // Main sequence.
   initial begin
      ref_clk = 1'b0;
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      mismatches = 0;
      samples_checked = 0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      ctl_chk(32'h0);
      rd(8'h20);
      chk(q, 32'h1);
      $display("test reset done");
      wt(1'b0, 5000);
      t0 = cyc;
      ctl_chk(32'h80);
      wr(8'h0c, 32'h1);
      wr(8'h00, 32'h60);
      busy_wait();
      wt(1'b0, 5000);
      chk(cyc - t0, 32'd4096);
      ctl_chk(32'h60);
      wt(1'b0, 5000);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, lnk.irq}, 32'h1);
      ctl_chk(32'he0);
      $display("test flag done");
      rd(8'h14);
      chk(q, 32'h1);
      wr(8'h18, 32'h1);
      rd(8'h1c);
      chk(q, 32'h2);
      chk({31'h0, irq_out}, 32'h1);
      wr(8'h14, 32'h1);
      rd(8'h14);
      chk(q, 32'h0);
      chk({31'h0, irq_out}, 32'h0);
      wr(8'h0c, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, lnk.irq}, 32'h0);
      wr(8'h0c, 32'h1);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, lnk.irq}, 32'h1);
      wr(8'h00, 32'h0);
      busy_wait();
      chk({31'h0, lnk.irq}, 32'h0);
      wr(8'h14, 32'h3);
      wr(8'h18, 32'h0);
      $display("test interrupt done");
      wr(8'h10, 32'h1);
      key(8'h1b);
      key(8'h1b);
      chk(trips, 32'd0);
      wr(8'h0c, 32'h3);
      wr(8'h10, 32'h1);
      wr(8'h0c, 32'h1);
      wr(8'h00, 32'h20);
      wt(1'b0, 5000);
      key(8'h1b);
      key(8'h5a);
      chk(trips, 32'd0);
      key(8'h1b);
      repeat (4) @(posedge ref_clk);
      chk(trips, 32'd1);
      rd(8'h14);
      chk(q, 32'h2);
      ctl_chk(32'h0);
      wr(8'h14, 32'h2);
      wt(1'b0, 5000);
      key(8'h1b);
      t0 = cyc;
      wt(1'b1, 62000);
      chk({31'h0, (cyc - t0 >= 57340 && cyc - t0 <= 61450)}, 32'h1);
      wr(8'h0c, 32'h7);
      wr(8'h10, 32'h0);
      wr(8'h0c, 32'h1);
      key(8'h1b);
      repeat (4) @(posedge ref_clk);
      chk(trips, 32'd3);
      wr(8'h0c, 32'h3);
      wr(8'h10, 32'h0);
      wr(8'h0c, 32'h1);
      key(8'h1b);
      key(8'h1b);
      repeat (4) @(posedge ref_clk);
      chk(trips, 32'd3);
      $display("test watchdog done");
      complete_run();
   end
endmodule : itwd_tb_top
